//--- ucf_params.svh
`ifndef UCF_PARAMS_SVH
`define UCF_PARAMS_SVH

// register offsets on the 3-bit address
`define UCF_ADDR_DATA 3'h0
`define UCF_ADDR_IER 3'h1
`define UCF_ADDR_ISR 3'h2
`define UCF_ADDR_LCR 3'h3
`define UCF_ADDR_MCR 3'h4
`define UCF_ADDR_LSR 3'h5
`define UCF_ADDR_MSR 3'h6
`define UCF_ADDR_SPR 3'h7

// line control fields
`define UCF_LCR_STOP 2
`define UCF_LCR_PAR 3
`define UCF_LCR_EVEN 4
`define UCF_LCR_STICK 5
`define UCF_LCR_BREAK 6
`define UCF_LCR_DLAB 7

// fifo control fields
`define UCF_FCR_EN 0
`define UCF_FCR_RXCLR 1
`define UCF_FCR_TXCLR 2
`define UCF_FCR_BLK 3

// interrupt enable and modem control fields
`define UCF_IER_RX 0
`define UCF_IER_TX 1
`define UCF_IER_LS 2
`define UCF_MCR_PRESC 7

// reset values
`define UCF_RST_BYTE 8'h00
`define UCF_RST_DIV 16'h0001

// interrupt identity codes
`define UCF_ISR_NONE 4'h1
`define UCF_ISR_TX 4'h2
`define UCF_ISR_RX 4'h4
`define UCF_ISR_LS 4'h6
`define UCF_ISR_TO 4'hC
`define UCF_ISR_FIFO 2'h3

// receive trigger levels (8, 16, 56, 60)
`define UCF_RXTRIG0 7'h08
`define UCF_RXTRIG1 7'h10
`define UCF_RXTRIG2 7'h38
`define UCF_RXTRIG3 7'h3C
// transmit trigger levels (8, 16, 32, 56)
`define UCF_TXTRIG0 7'h08
`define UCF_TXTRIG1 7'h10
`define UCF_TXTRIG2 7'h20
`define UCF_TXTRIG3 7'h38

// oversampling timing
`define UCF_HALF_BIT 4'h7
`define UCF_BIT_LAST 4'hF
`define UCF_PRESC_LAST 2'h3
`define UCF_MIN_BITS 4'h5
`define UCF_TO_EXTRA_BITS 6'h0C

`endif

//--- ucf_pkg.sv
package ucf_pkg;
    // gray codes along idle-start-data-parity-stop
    typedef enum logic [2:0] {
        UCF_IDLE = 3'h0,
        UCF_START = 3'h1,
        UCF_DATA = 3'h3,
        UCF_PARITY = 3'h2,
        UCF_STOP = 3'h6
    } ucf_state_t;
endpackage

//--- ucf_fifo.sv
`timescale 1ns/10ps
module ucf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk_i, // core clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic clr_i, // flush all entries
    input wire logic push_i, // write one entry, caller checks room
    input wire logic [WIDTH-1:0] din_i, // entry written
    input wire logic pop_i, // drop head entry, caller checks data
    output logic [WIDTH-1:0] dout_o, // head entry
    output logic [AW:0] count_o // entries held
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;

    assign dout_o = mem[rd_ptr];

    // storage has no reset, pointers define what is valid
    always_ff @(posedge clk_i) begin
        if (push_i) begin
            mem[wr_ptr] <= din_i;
        end
    end

    // pointers step to the next location on each access
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count_o <= '0;
        end else if (clr_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count_o <= '0;
        end else begin
            if (push_i) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop_i) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push_i && !pop_i) begin
                count_o <= count_o + 1'b1;
            end else if (pop_i && !push_i) begin
                count_o <= count_o - 1'b1;
            end
        end
    end
endmodule

//--- ucf_baud.sv
`timescale 1ns/10ps
`include "ucf_params.svh"
module ucf_baud #(
    parameter int DIV_W = 16
) (
    input wire logic clk_i, // core clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic presc4_i, // 1 divides input clock by 4
    input wire logic [DIV_W-1:0] divisor_i, // 16x divisor
    output logic tick_o // one-cycle 16x sampling pulse
);
    logic [1:0] pre_cnt;
    logic [DIV_W-1:0] div_cnt;
    wire pre_tick = !presc4_i || (pre_cnt == `UCF_PRESC_LAST);
    wire div_hit = (div_cnt >= divisor_i - DIV_W'(1));

    // divisor 0 wraps and behaves as 65536, never stalls
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_cnt <= '0;
            div_cnt <= '0;
            tick_o <= 1'b0;
        end else begin
            pre_cnt <= pre_cnt + 2'h1;
            tick_o <= pre_tick && div_hit;
            if (pre_tick) begin
                div_cnt <= div_hit ? '0 : div_cnt + DIV_W'(1);
            end
        end
    end
endmodule

//--- ucf_core.sv
// Function
// - fifo off, transmit interrupt high when holding register empty, else low.
// - fifo on, transmit interrupt low above trigger, high below it or empty.
// - fifo off, receive interrupt high while a received byte is held.
// - fifo on, receive interrupt high at or above receive trigger level.
// - fifo off, rx_ready_n low while one byte held, high when none.
// - fifo on, single mode, rx_ready_n low while receive fifo not empty.
// - block mode, rx_ready_n falls at trigger or time-out, rises when empty.
// - fifo off, tx_ready_n low when holding register empty, high otherwise.
// - fifo on, single mode, tx_ready_n low only when transmit fifo empty.
// - block mode, tx_ready_n low while transmit fifo has free room.
// - prescaler bit selects divide by 1 (default) or by 4.
// - 16-bit divisor turns prescaled clock into sixteen-times bit clock.
// - every transmitted bit lasts sixteen oversampling ticks.
// - frame is start, data bits, optional parity, then stop bits.
// - data leaves least significant bit first.
// - holding register writes enter a 64-entry transmit fifo.
// - fifo off, holding-empty on move to shifter, shifter-empty when idle.
// - fifo on, holding-empty when fifo empty, shifter-empty when both empty.
// - transmit-empty interrupt shows in status only while enabled.
// - start bit validated by sampling low eight ticks after falling edge.
// - all bits sampled at centre, errors reported in three status bits.
// - reading receive data pops fifo and updates error bits at once.
// - receive ready per byte or trigger, time-out after 4 chars plus 12 bits.
// - receive fifo entries hold 8 data bits plus three error tags.
`timescale 1ns/10ps
`include "ucf_params.svh"
module ucf_core #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic CORE_CLK_I, // oscillator clock, 10 MHz
    input wire logic ARST_N_I, // async reset, active low
    input wire logic [2:0] ADDR_I, // register address
    input wire logic [7:0] WDATA_I, // write data
    input wire logic WR_I, // one-cycle write strobe
    input wire logic RD_I, // one-cycle read strobe
    output logic [7:0] RDATA_O, // read data, valid after RD_I
    input wire logic RX_I, // serial receive line
    output logic TX_O, // serial transmit line
    output logic INT_O, // interrupt, active high
    output logic RX_READY_N_O, // receive ready, active low
    output logic TX_READY_N_O // transmit ready, active low
);
    localparam int CW = AW + 1;

    // programmable registers
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] irq_enable;
    logic [7:0] spr;
    logic [15:0] divisor;
    logic fifo_en;
    logic blk_mode;
    logic [1:0] rx_trig_sel;
    logic [1:0] tx_trig_sel;

    // address decode
    wire dlab = line_control[`UCF_LCR_DLAB];
    wire sel_data = (ADDR_I == `UCF_ADDR_DATA);
    wire sel_ier = (ADDR_I == `UCF_ADDR_IER);
    wire sel_isr = (ADDR_I == `UCF_ADDR_ISR);
    wire sel_lcr = (ADDR_I == `UCF_ADDR_LCR);
    wire sel_mcr = (ADDR_I == `UCF_ADDR_MCR);
    wire sel_lsr = (ADDR_I == `UCF_ADDR_LSR);
    wire sel_spr = (ADDR_I == `UCF_ADDR_SPR);
    wire wr_thr = WR_I && sel_data && !dlab;
    wire wr_dll = WR_I && sel_data && dlab;
    wire wr_dlm = WR_I && sel_ier && dlab;
    wire wr_ier = WR_I && sel_ier && !dlab;
    wire wr_fcr = WR_I && sel_isr;
    wire rd_rhr = RD_I && sel_data && !dlab;
    wire rd_lsr = RD_I && sel_lsr;

    // toggling fifo enable flushes both fifos, avoiding stale mixed-mode data
    wire en_flip = wr_fcr && (WDATA_I[`UCF_FCR_EN] != fifo_en);
    wire clr_tx = wr_fcr && (WDATA_I[`UCF_FCR_TXCLR] || en_flip);
    wire clr_rx = wr_fcr && (WDATA_I[`UCF_FCR_RXCLR] || en_flip);

    // register writes
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            line_control <= `UCF_RST_BYTE;
            modem_control <= `UCF_RST_BYTE;
            irq_enable <= `UCF_RST_BYTE;
            spr <= `UCF_RST_BYTE;
            divisor <= `UCF_RST_DIV;
            fifo_en <= 1'b0;
            blk_mode <= 1'b0;
            rx_trig_sel <= 2'h0;
            tx_trig_sel <= 2'h0;
        end else begin
            if (WR_I && sel_lcr) line_control <= WDATA_I;
            if (WR_I && sel_mcr) modem_control <= WDATA_I;
            if (WR_I && sel_spr) spr <= WDATA_I;
            if (wr_ier) irq_enable <= WDATA_I;
            if (wr_dll) divisor[7:0] <= WDATA_I;
            if (wr_dlm) divisor[15:8] <= WDATA_I;
            if (wr_fcr) begin
                fifo_en <= WDATA_I[`UCF_FCR_EN];
                blk_mode <= WDATA_I[`UCF_FCR_BLK];
                tx_trig_sel <= WDATA_I[5:4];
                rx_trig_sel <= WDATA_I[7:6];
            end
        end
    end

    // framing shared by both directions
    wire [3:0] data_bits = `UCF_MIN_BITS + {2'h0, line_control[1:0]};
    wire [2:0] last_idx = data_bits[2:0] - 3'h1;
    wire [7:0] data_mask = 8'hFF >> {1'b0, ~line_control[1:0]};
    wire par_en = line_control[`UCF_LCR_PAR];
    wire stop_two = line_control[`UCF_LCR_STOP];
    wire par_even = line_control[`UCF_LCR_EVEN];
    wire par_stick = line_control[`UCF_LCR_STICK];
    wire [3:0] char_bits = data_bits + 4'h2 + {3'h0, par_en} + {3'h0, stop_two};

    // baud generator
    logic tick;
    ucf_baud #(.DIV_W(16)) u_baud (
        .clk_i(CORE_CLK_I),
        .rst_n_i(ARST_N_I),
        .presc4_i(modem_control[`UCF_MCR_PRESC]),
        .divisor_i(divisor),
        .tick_o(tick)
    );

    // transmit fifo; without fifo it holds a single byte as holding register
    logic [7:0] tx_head;
    logic [CW-1:0] tx_cnt;
    logic [CW-1:0] rx_cnt;
    logic [10:0] rx_head;
    ucf_pkg::ucf_state_t tx_state;
    ucf_pkg::ucf_state_t next_tx_state;
    ucf_pkg::ucf_state_t rx_state;
    ucf_pkg::ucf_state_t next_rx_state;
    logic [3:0] tx_sub, next_tx_sub;
    logic [2:0] tx_idx, next_tx_idx;
    logic [7:0] tx_shift, next_tx_shift;
    logic tx_par, next_tx_par;
    logic tx_second, next_tx_second;
    logic tx_line, next_tx_line;
    logic [3:0] rx_sub, next_rx_sub;
    logic [2:0] rx_idx, next_rx_idx;
    logic [7:0] rx_shift, next_rx_shift;
    logic rx_pe, next_rx_pe;
    logic rx_push;
    logic rx_prev;
    logic overrun;
    logic [3:0] to_sub;
    logic [5:0] to_bits;
    logic to_flag;
    logic blk_rx_flag;
    logic [7:0] rd_mux;

    // one-deep use of the fifo stands in for the holding register
    wire tx_empty = (tx_cnt == '0);
    wire tx_room = fifo_en ? (tx_cnt != CW'(DEPTH)) : tx_empty;
    wire tx_push = wr_thr && tx_room;
    wire tx_load = (tx_state == ucf_pkg::UCF_IDLE) && !tx_empty;
    wire tx_idle = tx_empty && (tx_state == ucf_pkg::UCF_IDLE);
    wire tx_bit_end = tick && (tx_sub == `UCF_BIT_LAST);
    wire [7:0] tx_data = tx_head & data_mask;
    wire tx_par_bit = par_stick ? !par_even : (par_even ? ^tx_data : ~^tx_data);

    ucf_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_txf (
        .clk_i(CORE_CLK_I),
        .rst_n_i(ARST_N_I),
        .clr_i(clr_tx),
        .push_i(tx_push),
        .din_i(WDATA_I),
        .pop_i(tx_load),
        .dout_o(tx_head),
        .count_o(tx_cnt)
    );

    // transmit framing; writes to a full fifo are dropped, not overwritten
    always_comb begin
        next_tx_state = tx_state;
        next_tx_sub = tx_sub;
        next_tx_idx = tx_idx;
        next_tx_shift = tx_shift;
        next_tx_par = tx_par;
        next_tx_second = tx_second;
        next_tx_line = tx_line;
        if (tick && (tx_state != ucf_pkg::UCF_IDLE)) begin
            next_tx_sub = tx_sub + 4'h1;
        end
        case (tx_state)
            ucf_pkg::UCF_IDLE: begin
                next_tx_line = 1'b1;
                if (tx_load) begin
                    next_tx_state = ucf_pkg::UCF_START;
                    next_tx_sub = 4'h0;
                    next_tx_shift = tx_data;
                    next_tx_par = tx_par_bit;
                    next_tx_second = 1'b0;
                    next_tx_line = 1'b0;
                end
            end
            ucf_pkg::UCF_START: if (tx_bit_end) begin
                next_tx_state = ucf_pkg::UCF_DATA;
                next_tx_idx = 3'h0;
                next_tx_line = tx_shift[0];
            end
            ucf_pkg::UCF_DATA: if (tx_bit_end) begin
                next_tx_shift = {1'b0, tx_shift[7:1]};
                next_tx_idx = tx_idx + 3'h1;
                if (tx_idx == last_idx) begin
                    next_tx_state = par_en ? ucf_pkg::UCF_PARITY : ucf_pkg::UCF_STOP;
                    next_tx_line = par_en ? tx_par : 1'b1;
                end else begin
                    next_tx_line = tx_shift[1];
                end
            end
            ucf_pkg::UCF_PARITY: if (tx_bit_end) begin
                next_tx_state = ucf_pkg::UCF_STOP;
                next_tx_line = 1'b1;
            end
            ucf_pkg::UCF_STOP: if (tx_bit_end) begin
                // second stop bit is a full bit, also for five-bit characters
                if (stop_two && !tx_second) begin
                    next_tx_second = 1'b1;
                end else begin
                    next_tx_state = ucf_pkg::UCF_IDLE;
                end
            end
            default: next_tx_state = ucf_pkg::UCF_IDLE;
        endcase
    end

    // transmit state
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tx_state <= ucf_pkg::UCF_IDLE;
            tx_sub <= 4'h0;
            tx_idx <= 3'h0;
            tx_shift <= `UCF_RST_BYTE;
            tx_par <= 1'b0;
            tx_second <= 1'b0;
            tx_line <= 1'b1;
        end else begin
            tx_state <= next_tx_state;
            tx_sub <= next_tx_sub;
            tx_idx <= next_tx_idx;
            tx_shift <= next_tx_shift;
            tx_par <= next_tx_par;
            tx_second <= next_tx_second;
            tx_line <= next_tx_line;
        end
    end

    // receive sampling helpers; idle level one avoids a false edge after reset
    wire rx_fall = rx_prev && !RX_I;
    wire rx_mid = tick && (rx_sub == `UCF_HALF_BIT);
    wire rx_bit_end = tick && (rx_sub == `UCF_BIT_LAST);
    wire [7:0] rx_data = rx_shift >> ~line_control[1:0];
    wire rx_par_exp = par_stick ? !par_even : (par_even ? ^rx_data : ~^rx_data);
    wire rx_room = fifo_en ? (rx_cnt != CW'(DEPTH)) : (rx_cnt == '0);
    wire rx_fe = !RX_I;
    wire [10:0] rx_entry = {rx_fe && (rx_data == 8'h00), rx_fe, rx_pe, rx_data};
    wire rx_wr = rx_push && rx_room;
    wire rx_pop = rd_rhr && (rx_cnt != '0);

    // receive framing, centre sampled from the validated start
    always_comb begin
        next_rx_state = rx_state;
        next_rx_sub = rx_sub;
        next_rx_idx = rx_idx;
        next_rx_shift = rx_shift;
        next_rx_pe = rx_pe;
        rx_push = 1'b0;
        if (tick) begin
            next_rx_sub = rx_sub + 4'h1;
        end
        case (rx_state)
            ucf_pkg::UCF_IDLE: if (rx_fall) begin
                next_rx_state = ucf_pkg::UCF_START;
                next_rx_sub = 4'h0;
            end
            ucf_pkg::UCF_START: if (rx_mid) begin
                next_rx_sub = 4'h0;
                next_rx_idx = 3'h0;
                next_rx_pe = 1'b0;
                next_rx_state = RX_I ? ucf_pkg::UCF_IDLE : ucf_pkg::UCF_DATA;
            end
            ucf_pkg::UCF_DATA: if (rx_bit_end) begin
                next_rx_shift = {RX_I, rx_shift[7:1]};
                next_rx_idx = rx_idx + 3'h1;
                if (rx_idx == last_idx) begin
                    next_rx_state = par_en ? ucf_pkg::UCF_PARITY : ucf_pkg::UCF_STOP;
                end
            end
            ucf_pkg::UCF_PARITY: if (rx_bit_end) begin
                next_rx_pe = (RX_I != rx_par_exp);
                next_rx_state = ucf_pkg::UCF_STOP;
            end
            ucf_pkg::UCF_STOP: if (rx_bit_end) begin
                rx_push = 1'b1;
                next_rx_state = ucf_pkg::UCF_IDLE;
            end
            default: next_rx_state = ucf_pkg::UCF_IDLE;
        endcase
    end

    // receive state
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rx_state <= ucf_pkg::UCF_IDLE;
            rx_sub <= 4'h0;
            rx_idx <= 3'h0;
            rx_shift <= `UCF_RST_BYTE;
            rx_pe <= 1'b0;
            rx_prev <= 1'b1;
        end else begin
            rx_state <= next_rx_state;
            rx_sub <= next_rx_sub;
            rx_idx <= next_rx_idx;
            rx_shift <= next_rx_shift;
            rx_pe <= next_rx_pe;
            rx_prev <= RX_I;
        end
    end

    ucf_fifo #(.WIDTH(11), .DEPTH(DEPTH), .AW(AW)) u_rxf (
        .clk_i(CORE_CLK_I),
        .rst_n_i(ARST_N_I),
        .clr_i(clr_rx),
        .push_i(rx_wr),
        .din_i(rx_entry),
        .pop_i(rx_pop),
        .dout_o(rx_head),
        .count_o(rx_cnt)
    );

    // trigger levels
    wire [CW-1:0] rx_trig = (rx_trig_sel == 2'h0) ? CW'(`UCF_RXTRIG0) :
        (rx_trig_sel == 2'h1) ? CW'(`UCF_RXTRIG1) :
        (rx_trig_sel == 2'h2) ? CW'(`UCF_RXTRIG2) : CW'(`UCF_RXTRIG3);
    wire [CW-1:0] tx_trig = (tx_trig_sel == 2'h0) ? CW'(`UCF_TXTRIG0) :
        (tx_trig_sel == 2'h1) ? CW'(`UCF_TXTRIG1) :
        (tx_trig_sel == 2'h2) ? CW'(`UCF_TXTRIG2) : CW'(`UCF_TXTRIG3);
    wire rx_at_trig = (rx_cnt >= rx_trig);

    // time-out restarts on every arrival or read so it marks a stalled stream
    wire [5:0] to_limit = {char_bits, 2'h0} + `UCF_TO_EXTRA_BITS;
    wire to_restart = rx_wr || rx_pop || (rx_cnt == '0) || !fifo_en;
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            to_sub <= 4'h0;
            to_bits <= 6'h00;
            to_flag <= 1'b0;
        end else if (to_restart) begin
            to_sub <= 4'h0;
            to_bits <= 6'h00;
            to_flag <= 1'b0;
        end else if (tick) begin
            to_sub <= to_sub + 4'h1;
            if ((to_sub == `UCF_BIT_LAST) && (to_bits != to_limit)) to_bits <= to_bits + 6'h01;
            if (to_bits == to_limit) to_flag <= 1'b1;
        end
    end

    // block-mode request and overrun; a set in the clearing cycle wins
    wire blk_on = fifo_en && blk_mode;
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            blk_rx_flag <= 1'b0;
            overrun <= 1'b0;
        end else begin
            if (rx_at_trig || to_flag) blk_rx_flag <= 1'b1;
            else if (rx_cnt == '0) blk_rx_flag <= 1'b0;
            if (rx_push && !rx_room) overrun <= 1'b1;
            else if (rd_lsr) overrun <= 1'b0;
        end
    end

    // status and interrupt sources
    wire rx_any = (rx_cnt != '0);
    wire [2:0] head_err = rx_any ? rx_head[10:8] : 3'h0;
    wire ls_src = (|head_err) || overrun;
    wire tx_int_src = fifo_en ? (tx_cnt <= tx_trig) : tx_empty;
    wire rx_int_src = fifo_en ? rx_at_trig : rx_any;
    wire to_int = fifo_en && to_flag;
    wire int_ls = irq_enable[`UCF_IER_LS] && ls_src;
    wire int_to = irq_enable[`UCF_IER_RX] && to_int;
    wire int_rx = irq_enable[`UCF_IER_RX] && rx_int_src;
    wire int_tx = irq_enable[`UCF_IER_TX] && tx_int_src;
    wire [3:0] isr_code = int_ls ? `UCF_ISR_LS : int_to ? `UCF_ISR_TO :
        int_rx ? `UCF_ISR_RX : int_tx ? `UCF_ISR_TX : `UCF_ISR_NONE;
    wire [7:0] irq_status = {(fifo_en ? `UCF_ISR_FIFO : 2'h0), 2'h0, isr_code};
    wire [7:0] line_status = {1'b0, tx_idle, tx_empty, head_err, overrun, rx_any};

    // pins
    assign INT_O = int_ls || int_to || int_rx || int_tx;
    assign RX_READY_N_O = blk_on ? !(blk_rx_flag && rx_any) : !rx_any;
    assign TX_READY_N_O = blk_on ? (tx_cnt == CW'(DEPTH)) : !tx_empty;
    assign TX_O = tx_line;

    // read selection; modem status has no pins here and reads zero
    always_comb begin
        rd_mux = `UCF_RST_BYTE;
        if (sel_data) rd_mux = dlab ? divisor[7:0] : rx_head[7:0];
        else if (sel_ier) rd_mux = dlab ? divisor[15:8] : irq_enable;
        else if (sel_isr) rd_mux = irq_status;
        else if (sel_lcr) rd_mux = line_control;
        else if (sel_mcr) rd_mux = modem_control;
        else if (sel_lsr) rd_mux = line_status;
        else if (sel_spr) rd_mux = spr;
    end

    // read data captured on the strobe edge, same edge pops the receive fifo
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RDATA_O <= `UCF_RST_BYTE;
        end else if (RD_I) begin
            RDATA_O <= rd_mux;
        end
    end
endmodule

//--- ucf_core_asserts.sv
`timescale 1ns/10ps
`include "ucf_params.svh"
module ucf_core_asserts (
    input wire logic CORE_CLK_I, // core clock
    input wire logic ARST_N_I, // reset, low
    input wire logic [2:0] ADDR_I, // address
    input wire logic [7:0] WDATA_I, // write data
    input wire logic WR_I, // write strobe
    input wire logic RD_I, // read strobe
    input wire logic [7:0] RDATA_O, // read data
    input wire logic RX_I, // serial in
    input wire logic TX_O, // serial out
    input wire logic INT_O, // interrupt
    input wire logic RX_READY_N_O, // rx ready
    input wire logic TX_READY_N_O // tx ready
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    logic dlab, fifo_on, wrote;
    logic [3:0] irq_enable;
    // shadow of control writes, so mode-dependent checks know the mode
    wire wr_lcr = WR_I && ADDR_I == `UCF_ADDR_LCR;
    wire wr_fcr = WR_I && ADDR_I == `UCF_ADDR_ISR;
    wire wr_ier = WR_I && ADDR_I == `UCF_ADDR_IER && !dlab;
    wire at_data = ADDR_I == `UCF_ADDR_DATA && !dlab;
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            {dlab, fifo_on, wrote, irq_enable} <= 7'h00;
        end else begin
            dlab <= wr_lcr ? WDATA_I[`UCF_LCR_DLAB] : dlab;
            fifo_on <= wr_fcr ? WDATA_I[`UCF_FCR_EN] : fifo_on;
            wrote <= wrote | (WR_I && at_data);
            irq_enable <= wr_ier ? WDATA_I[3:0] : irq_enable;
        end
    end
    a_start_min_width: assert property ($fell(TX_O) |-> !TX_O[*8])
        else $error("transmit low level too short");
    a_mark_min_width: assert property ($rose(TX_O) |-> TX_O[*8])
        else $error("transmit high level too short");
    a_frame_needs_data: assert property ($fell(TX_O) |-> wrote)
        else $error("frame sent with no byte written");
    a_reset_idle_pins: assert property ($rose(ARST_N_I) |->
        TX_O && !TX_READY_N_O && RX_READY_N_O && !INT_O)
        else $error("pins not idle after reset");
    a_int_quiet_off: assert property (irq_enable == 4'h0 && $past(irq_enable) == 4'h0 |-> !INT_O)
        else $error("interrupt with all sources off");
    a_rx_byte_int: assert property (!fifo_on && irq_enable[0] && $fell(RX_READY_N_O)
        |-> ##[0:2] INT_O)
        else $error("no interrupt for held byte");
    a_rx_after_stop: assert property ($fell(RX_READY_N_O) |-> $past(RX_I) && $past(RX_I, 2))
        else $error("receive ready without stop level");
    a_rx_read_clears: assert property (!fifo_on && RD_I && at_data && !RX_READY_N_O
        |-> ##[1:2] RX_READY_N_O)
        else $error("receive ready stays after read");
endmodule
bind ucf_core ucf_core_asserts u_chk (.*);

//--- ucf_remote.sv
`timescale 1ns/10ps
module ucf_remote (
    input wire logic clk_i, // core clock
    input wire logic tx_i, // line from the core
    input int bit_cycles_i, // clocks per bit
    output logic rx_o // line into the core
);
    logic [7:0] got;
    int count = 0;
    initial rx_o = 1'h1;
    // one frame: start, eight data lsb first, one stop
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++) begin
            rx_o <= f[i];
            repeat (bit_cycles_i) @(posedge clk_i);
        end
    endtask
    // sample core frames at bit centres; the stop bit is not judged
    initial forever begin
        @(negedge tx_i);
        repeat (bit_cycles_i / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cycles_i) @(posedge clk_i);
            got[i] = tx_i;
        end
        repeat (bit_cycles_i) @(posedge clk_i);
        count++;
    end
endmodule

//--- ucf_core_test.sv
`timescale 1ns/10ps
`include "ucf_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ucf_core_test;
    logic clk = 1'h0, arst_n = 1'h0, wr = 1'h0, rd = 1'h0, rx, tx, irq, rxr_n, txr_n;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, q;
    int mismatches = 0, checks = 0, bc = 16;
    always #50 clk = ~clk;
    ucf_core DUT (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RX_I(rx), .TX_O(tx), .INT_O(irq),
        .RX_READY_N_O(rxr_n), .TX_READY_N_O(txr_n));
    ucf_remote rem (.clk_i(clk), .tx_i(tx), .bit_cycles_i(bc), .rx_o(rx));
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        {addr, wdata, wr} <= {a, d, 1'h1};
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        {addr, rd} <= {a, 1'h1};
        @(posedge clk);
        rd <= 1'h0;
        @(negedge clk);
        d = rdata;
    endtask
    // bounded wait on receive ready level or on frames seen by the remote
    task automatic await(input bit on_rx, input int n);
        int k;
        k = 0;
        while ((on_rx ? rxr_n !== n[0] : rem.count < n) && k < 20000) begin
            @(negedge clk);
            k++;
        end
        if (k == 20000) begin
            mismatches++;
            test_done();
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'h1;
        @(negedge clk);
        `CHK({tx, txr_n, rxr_n, irq}, 4'hA)
        wr_reg(`UCF_ADDR_LCR, 8'h03);
        wr_reg(`UCF_ADDR_DATA, 8'hA5);
        await(0, 1);
        `CHK(rem.got, 8'hA5)
        repeat (bc) @(negedge clk);
        rd_reg(`UCF_ADDR_LSR, q);
        `CHK(q & 8'h60, 8'h60)
        // prescaler by four, then divisor two at divide by one
        wr_reg(`UCF_ADDR_MCR, 8'h80);
        bc = 64;
        wr_reg(`UCF_ADDR_DATA, 8'h3C);
        await(0, 2);
        `CHK(rem.got, 8'h3C)
        repeat (bc) @(negedge clk);
        wr_reg(`UCF_ADDR_MCR, 8'h00);
        wr_reg(`UCF_ADDR_LCR, 8'h83);
        wr_reg(`UCF_ADDR_DATA, 8'h02);
        wr_reg(`UCF_ADDR_IER, 8'h00);
        wr_reg(`UCF_ADDR_LCR, 8'h03);
        bc = 32;
        wr_reg(`UCF_ADDR_DATA, 8'hC3);
        await(0, 3);
        `CHK(rem.got, 8'hC3)
        wr_reg(`UCF_ADDR_IER, 8'h01);
        rem.send(8'h5A);
        `CHK({irq, rxr_n}, 2'h2)
        rd_reg(`UCF_ADDR_DATA, q);
        `CHK(q, 8'h5A)
        `CHK(rxr_n, 1'h1)
        // fifo on, single-character mode
        wr_reg(`UCF_ADDR_IER, 8'h00);
        wr_reg(`UCF_ADDR_ISR, 8'h07);
        for (int i = 1; i < 4; i++) wr_reg(`UCF_ADDR_DATA, 8'h11 * i[7:0]);
        @(negedge clk);
        `CHK(txr_n, 1'h1)
        await(0, 6);
        `CHK({rem.got, txr_n}, 9'h066)
        rem.send(8'h81);
        rem.send(8'h7E);
        `CHK(rxr_n, 1'h0)
        rd_reg(`UCF_ADDR_DATA, q);
        `CHK(q, 8'h81)
        rd_reg(`UCF_ADDR_DATA, q);
        `CHK(q, 8'h7E)
        `CHK(rxr_n, 1'h1)
        // block mode: one byte stays below trigger until the time-out
        wr_reg(`UCF_ADDR_ISR, 8'h0F);
        @(negedge clk);
        `CHK(txr_n, 1'h0)
        rem.send(8'h42);
        `CHK(rxr_n, 1'h1)
        await(1, 0);
        rd_reg(`UCF_ADDR_DATA, q);
        `CHK({q, rxr_n}, 9'h085)
        for (int i = 0; i < 65; i++) wr_reg(`UCF_ADDR_DATA, i[7:0]);
        @(negedge clk);
        `CHK(txr_n, 1'h1)
        test_done();
    end
endmodule
